// ==== iqo_pkg.sv ====
// Constants and a decode helper for the interpolation quadrature output block
//
// Behaviour
// - Resolution code selects angle steps per period and interpolation factor.
// - Interpolation factor equals A output frequency over sine input frequency.
// - Steps counted edge to edge on A and B, four per factor unit.
// - Resolution four gives A and B at the sine input frequency.
// - Hysteresis codes 0 to 13 give multiples of 0.9 degree.
// - Hysteresis code E gives half a step, code F one full step.
// - Internal A/B cycles within each period are counted; count equals factor.
// - Cycle count is zero at phase zero and ends at factor minus one.
// - Each internal cycle runs 11, 10, 00, 01 for A and B.
// - Config bit 7 inverts A; complementary pin is the opposite.
// - Config bit 6 inverts B; complementary pin is the opposite.
// - Config bit 5 inverts index; complementary pin is the opposite.
// - Config bit 4 exchanges which internal channel carries A and B.
// - Config bits 3:0 enable the index for each A/B state.
// - Index cycle select bit 7 restricts index to cycle matching bits 6:0.
// - An unreachable selected cycle yields no index pulse at all.
// - Sync select 0 follows index channel; 1 aligns index to A/B edges.
package iqo_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int ANG_W  = 16;
    localparam int STEP_W = 9;
    localparam int CYC_W  = 7;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SYNC    = 8'h02;
    localparam logic [7:0] OFS_OUT_CFG = 8'h19;
    localparam logic [7:0] OFS_IDX_POS = 8'h1A;
    localparam logic [7:0] OFS_RES     = 8'h1B;
    localparam logic [7:0] OFS_HYS     = 8'h1D;
    localparam logic [7:0] OFS_STATUS  = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SYNC_BIT  = 4;
    localparam int INV_A_BIT = 7;
    localparam int INV_B_BIT = 6;
    localparam int INV_Z_BIT = 5;
    localparam int SWAP_BIT  = 4;
    localparam int MASK_BIT  = 7;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_OUT_CFG = 8'h08;
    localparam logic [7:0]  RST_IDX_POS = 8'h00;
    localparam logic [14:0] RST_RES     = 15'h00E0;
    localparam logic [3:0]  RST_HYS     = 4'h0;
    localparam logic [6:0]  RST_IPF     = 7'h01;

    // ------------------------------------------------------------
    // Hysteresis: unit in angle units of 1/65536 period, widths in fractional step units of 1/65536 step
    // ------------------------------------------------------------
    localparam logic [11:0] HYS_UNIT_ANG = 12'h0A4;
    localparam logic [3:0]  HYS_HALF_CODE = 4'hE;
    localparam logic [3:0]  HYS_FULL_CODE = 4'hF;
    localparam logic [25:0] HYS_HALF = 26'h0008000;
    localparam logic [25:0] HYS_FULL = 26'h0010000;
    localparam logic [25:0] ONE_STEP = 26'h0010000;

    // Factor per resolution code; zero marks an unknown code
    function automatic logic [6:0] res_to_ipf(input logic [14:0] code);
        logic [6:0] f;
        case (code)
            15'h00E0: f = 7'h01;
            15'h01B0: f = 7'h02;
            15'h02A0: f = 7'h03;
            15'h0398: f = 7'h04;
            15'h0414: f = 7'h05;
            15'h0590: f = 7'h06;
            15'h078C: f = 7'h08;
            15'h090A: f = 7'h0A;
            15'h0B88: f = 7'h0C;
            15'h0F86: f = 7'h10;
            15'h1305: f = 7'h14;
            15'h1784: f = 7'h18;
            15'h1804: f = 7'h19;
            15'h1F83: f = 7'h20;
            15'h2F82: f = 7'h30;
            15'h3102: f = 7'h32;
            15'h5F81: f = 7'h60;
            15'h6301: f = 7'h64;
            default:  f = 7'h00;
        endcase
        return f;
    endfunction

endpackage

// ==== iqo_sync.sv ====
// Two-stage synchroniser for a level arriving from outside the clock domain
`timescale 1ns/10ps
module iqo_sync #(
    parameter int STAGES = 2
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Level in and out
    input  wire logic i_async,
    output logic      o_sync
);

    typedef struct packed {
        logic [STAGES-1:0] sh;
    } iqo_sync_s;

    iqo_sync_s st_reg;
    iqo_sync_s st_next;

    // Fewer than two stages cannot guard against metastability
    if (STAGES < 2) begin : g_bad
        $error("iqo_sync needs at least two stages");
    end

    always_comb begin
        st_next    = st_reg;
        st_next.sh = {st_reg.sh[STAGES-2:0], i_async};
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_sync = st_reg.sh[STAGES-1];

endmodule

// ==== iqo_top.sv ====
// Tracking step counter, quadrature and index output logic with its registers
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
module iqo_top #(
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    // Register port
    input  wire logic [iqo_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [iqo_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    output logic      [iqo_pkg::DATA_W-1:0] o_rdata,
    // Converter angle and index gate
    input  wire logic [iqo_pkg::ANG_W-1:0]  i_angle,
    input  wire logic                       i_index_gate,
    // Incremental outputs
    output logic                            o_out_a_true,
    output logic                            o_out_a_comp,
    output logic                            o_out_b_true,
    output logic                            o_out_b_comp,
    output logic                            o_out_index_true,
    output logic                            o_out_index_comp
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  out_cfg;
        logic [7:0]  idx_pos;
        logic [14:0] res_code;
        logic [3:0]  hys;
        logic        sync_sel;
        logic [6:0]  interpolation_factor;
        logic [8:0]  step;
        logic        z;
        logic        a_t;
        logic        a_c;
        logic        b_t;
        logic        b_c;
        logic        z_t;
        logic        z_c;
        logic [15:0] rdata;
    } iqo_state_s;

    iqo_state_s st_reg;
    iqo_state_s st_next;

    logic        gate_s;
    logic [8:0]  step_cnt;
    logic [24:0] prod;
    logic [24:0] modulus;
    logic [24:0] base;
    logic [25:0] half;
    logic [25:0] diff;
    logic [25:0] hys_w;
    logic [11:0] hys_ang;
    logic [20:0] hys_prod;
    logic [6:0]  new_ipf;
    logic        a_n;
    logic        b_n;
    logic        first_n;
    logic        second_n;
    logic [6:0]  cyc_n;
    logic [1:0]  sel_n;
    logic        en_n;
    logic        mask_ok;
    logic        zi_n;
    logic        moved;

    // ------------------------------------------------------------
    // Gate synchroniser
    // ------------------------------------------------------------
    iqo_sync #(
        .STAGES  (SYNC_STAGES)
    ) u_gate_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_index_gate),
        .o_sync  (gate_s)
    );

    // ------------------------------------------------------------
    // Tracking arithmetic
    // ------------------------------------------------------------
    // Scaling by the step count avoids any divider; one step per clock
    always_comb begin
        step_cnt = {st_reg.interpolation_factor, 2'b00};
        prod     = {9'h000, i_angle} * {16'h0000, step_cnt};
        modulus  = {step_cnt, 16'h0000};
        base     = {st_reg.step, 16'h0000};
        half     = {2'b00, modulus[24:1]};
        diff     = {1'b0, prod} - {1'b0, base};
        // Fold the difference into the nearest half period
        if ($signed(diff) > $signed(half)) begin
            diff = diff - {1'b0, modulus};
        end else if ($signed(diff) < -$signed(half)) begin
            diff = diff + {1'b0, modulus};
        end
    end

    // Hysteresis width in the same fractional step units
    always_comb begin
        hys_ang  = 12'(st_reg.hys * iqo_pkg::HYS_UNIT_ANG);
        // Operands widened first so the product keeps all its bits
        hys_prod = {9'h000, hys_ang} * {12'h000, step_cnt};
        case (st_reg.hys)
            4'h0: begin
                hys_w = 26'h0000000;
            end
            iqo_pkg::HYS_HALF_CODE: begin
                hys_w = iqo_pkg::HYS_HALF;
            end
            iqo_pkg::HYS_FULL_CODE: begin
                hys_w = iqo_pkg::HYS_FULL;
            end
            default: begin
                hys_w = {5'h00, hys_prod};
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        new_ipf = iqo_pkg::res_to_ipf(i_wdata[14:0]);

        // Register writes
        if (i_wr) begin
            case (i_addr)
                iqo_pkg::OFS_SYNC: begin
                    st_next.sync_sel = i_wdata[iqo_pkg::SYNC_BIT];
                end
                iqo_pkg::OFS_OUT_CFG: begin
                    st_next.out_cfg = i_wdata[7:0];
                end
                iqo_pkg::OFS_IDX_POS: begin
                    st_next.idx_pos = i_wdata[7:0];
                end
                iqo_pkg::OFS_RES: begin
                    st_next.res_code = i_wdata[14:0];
                    // Unknown codes leave the factor unchanged
                    if (new_ipf != 7'h00) begin
                        st_next.interpolation_factor = new_ipf;
                    end
                end
                iqo_pkg::OFS_HYS: begin
                    st_next.hys = i_wdata[3:0];
                end
                default: begin
                end
            endcase
        end

        // Register reads; data stand one cycle only
        st_next.rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                iqo_pkg::OFS_SYNC: begin
                    st_next.rdata[iqo_pkg::SYNC_BIT] = st_reg.sync_sel;
                end
                iqo_pkg::OFS_OUT_CFG: begin
                    st_next.rdata = {8'h00, st_reg.out_cfg};
                end
                iqo_pkg::OFS_IDX_POS: begin
                    st_next.rdata = {8'h00, st_reg.idx_pos};
                end
                iqo_pkg::OFS_RES: begin
                    st_next.rdata = {1'b0, st_reg.res_code};
                end
                iqo_pkg::OFS_HYS: begin
                    st_next.rdata = {12'h000, st_reg.hys};
                end
                iqo_pkg::OFS_STATUS: begin
                    st_next.rdata = {st_reg.interpolation_factor, st_reg.step};
                end
                default: begin
                    st_next.rdata = 16'h0000;
                end
            endcase
        end

        // Step tracking: at most one step per clock keeps edges clean
        if (st_reg.step >= step_cnt) begin
            // Shrunk resolution: walk back in single steps
            st_next.step = st_reg.step - 9'h001;
        end else if ($signed(diff) >= $signed(iqo_pkg::ONE_STEP + hys_w)) begin
            if (st_reg.step == step_cnt - 9'h001) begin
                st_next.step = 9'h000;
            end else begin
                st_next.step = st_reg.step + 9'h001;
            end
        end else if ($signed(diff + hys_w) < 0) begin
            if (st_reg.step == 9'h000) begin
                st_next.step = step_cnt - 9'h001;
            end else begin
                st_next.step = st_reg.step - 9'h001;
            end
        end
        moved = (st_next.step != st_reg.step);

        // Quadrature state from the step: 11, 10, 00, 01
        a_n   = ~st_next.step[1];
        b_n   = ~(st_next.step[1] ^ st_next.step[0]);
        cyc_n = st_next.step[8:2];

        // Channel assignment
        if (st_next.out_cfg[iqo_pkg::SWAP_BIT]) begin
            first_n  = b_n;
            second_n = a_n;
        end else begin
            first_n  = a_n;
            second_n = b_n;
        end

        // Index channel
        sel_n   = {a_n, ~(a_n ^ b_n)};
        en_n    = st_next.out_cfg[sel_n];
        mask_ok = ~st_next.idx_pos[iqo_pkg::MASK_BIT]
                | ((st_next.idx_pos[6:0] < st_next.interpolation_factor)
                   & (cyc_n == st_next.idx_pos[6:0]));
        zi_n    = gate_s & en_n & mask_ok;

        // Follow the channel, or only pick it up on an A/B edge
        if (!st_next.sync_sel || moved) begin
            st_next.z = zi_n;
        end

        // Output stage with inversion
        st_next.a_t = first_n ^ st_next.out_cfg[iqo_pkg::INV_A_BIT];
        st_next.a_c = ~st_next.a_t;
        st_next.b_t = second_n ^ st_next.out_cfg[iqo_pkg::INV_B_BIT];
        st_next.b_c = ~st_next.b_t;
        st_next.z_t = st_next.z ^ st_next.out_cfg[iqo_pkg::INV_Z_BIT];
        st_next.z_c = ~st_next.z_t;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg          <= '0;
            st_reg.out_cfg  <= iqo_pkg::RST_OUT_CFG;
            st_reg.idx_pos  <= iqo_pkg::RST_IDX_POS;
            st_reg.res_code <= iqo_pkg::RST_RES;
            st_reg.hys      <= iqo_pkg::RST_HYS;
            st_reg.interpolation_factor      <= iqo_pkg::RST_IPF;
            // Step zero is A=1 B=1 with default config
            st_reg.a_t      <= 1'b1;
            st_reg.b_t      <= 1'b1;
            st_reg.z_c      <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata          = st_reg.rdata;
    assign o_out_a_true     = st_reg.a_t;
    assign o_out_a_comp     = st_reg.a_c;
    assign o_out_b_true     = st_reg.b_t;
    assign o_out_b_comp     = st_reg.b_c;
    assign o_out_index_true = st_reg.z_t;
    assign o_out_index_comp = st_reg.z_c;

endmodule

// ==== iqo_top_properties.sv ====
// Port-level assertions for the quadrature output block, bound to iqo_top
`timescale 1ns/10ps
module iqo_top_properties #(
    parameter int SYNC_STAGES = 2
) (
    // Clock, reset and register port
    input wire logic                       i_clk,
    input wire logic                       i_rst,
    input wire logic [iqo_pkg::ADDR_W-1:0] i_addr,
    input wire logic [iqo_pkg::DATA_W-1:0] i_wdata,
    input wire logic                       i_wr,
    input wire logic                       i_rd,
    input wire logic [iqo_pkg::DATA_W-1:0] o_rdata,
    // Converter side and pins
    input wire logic [iqo_pkg::ANG_W-1:0]  i_angle,
    input wire logic                       i_index_gate,
    input wire logic                       o_out_a_true,
    input wire logic                       o_out_a_comp,
    input wire logic                       o_out_b_true,
    input wire logic                       o_out_b_comp,
    input wire logic                       o_out_index_true,
    input wire logic                       o_out_index_comp
);
    // ------------------------------------------------------------
    // Shadow settings
    // ------------------------------------------------------------
    // Edge and index pin checks wait three quiet cycles, since a write may flip pins
    logic [7:0] cfg_reg;
    logic       sync_reg;
    logic [1:0] quiet_reg;
    logic [1:0] ab_reg;
    logic       p1;
    logic       p2;
    logic       int_a;
    logic       int_b;
    logic       en_now;
    logic       zint;
    logic       calm;
    assign p1     = o_out_a_true ^ cfg_reg[7];
    assign p2     = o_out_b_true ^ cfg_reg[6];
    assign int_a  = cfg_reg[4] ? p2 : p1;
    assign int_b  = cfg_reg[4] ? p1 : p2;
    assign en_now = cfg_reg[{int_a, int_a ~^ int_b}];
    assign zint   = o_out_index_true ^ cfg_reg[5];
    assign calm   = quiet_reg == 2'h3;
    always_ff @(posedge i_clk) begin
        ab_reg <= {o_out_a_true, o_out_b_true};
        if (i_rst) begin
            cfg_reg   <= iqo_pkg::RST_OUT_CFG;
            sync_reg  <= 1'b0;
            quiet_reg <= 2'h3;
        end else if (i_wr) begin
            quiet_reg <= 2'h0;
            if (i_addr == iqo_pkg::OFS_OUT_CFG) cfg_reg <= i_wdata[7:0];
            if (i_addr == iqo_pkg::OFS_SYNC) sync_reg <= i_wdata[iqo_pkg::SYNC_BIT];
        end else if (!calm) begin
            quiet_reg <= quiet_reg + 2'h1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_rd_cfg; i_rd && i_addr == iqo_pkg::OFS_OUT_CFG; endsequence
    sequence s_rd_hys; i_rd && i_addr == iqo_pkg::OFS_HYS; endsequence
    property p_a_comp; o_out_a_comp == !o_out_a_true; endproperty
    a_a_comp: assert property (p_a_comp) else $error("A complement wrong");
    property p_b_comp; o_out_b_comp == !o_out_b_true; endproperty
    a_b_comp: assert property (p_b_comp) else $error("B complement wrong");
    property p_z_comp; o_out_index_comp == !o_out_index_true; endproperty
    a_z_comp: assert property (p_z_comp) else $error("index complement wrong");
    property p_one_edge; calm && $changed(o_out_a_true) |-> $stable(o_out_b_true); endproperty
    a_one_edge: assert property (p_one_edge) else $error("A and B moved together");
    property p_rd_idle; !i_rd |=> o_rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_hys_rd; s_rd_hys |=> o_rdata[15:4] == 12'h000; endproperty
    a_hys_rd: assert property (p_hys_rd) else $error("hysteresis upper bits set");
    property p_cfg_back; s_rd_cfg |=> o_rdata == {8'h00, cfg_reg}; endproperty
    a_cfg_back: assert property (p_cfg_back) else $error("config readback wrong");
    property p_idx_en; calm && !sync_reg && zint |-> en_now || $past(en_now); endproperty
    a_idx_en: assert property (p_idx_en) else $error("index in disabled state");
    property p_gate;
        calm && !sync_reg && $rose(zint) |-> $past(i_index_gate, 2) || $past(i_index_gate, 3);
    endproperty
    a_gate: assert property (p_gate) else $error("index without gate");
    property p_sync_hold;
        calm && sync_reg && ab_reg == {o_out_a_true, o_out_b_true} && $stable(ab_reg)
            |-> $stable(o_out_index_true);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("index moved without step");
endmodule

bind iqo_top iqo_top_properties #(.SYNC_STAGES(SYNC_STAGES)) iqo_top_properties_i (
    .i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_angle, .i_index_gate,
    .o_out_a_true, .o_out_a_comp, .o_out_b_true, .o_out_b_comp, .o_out_index_true,
    .o_out_index_comp
);

// ==== iqo_counter_model.sv ====
// Behavioural up/down counter evaluating the quadrature pins
`timescale 1ns/10ps
module iqo_counter_model (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Pins
    input  wire logic        i_a_true,
    input  wire logic        i_b_true,
    // Count and double-edge tally
    output logic signed [15:0] o_pos,
    output logic [7:0]       o_bad
);
    logic [1:0] ph_reg;
    logic [1:0] ph;
    // Phase order 11, 10, 00, 01 maps to 0..3
    assign ph = {~i_a_true, i_a_true ^ i_b_true};
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ph_reg <= 2'h0;
            o_pos  <= 16'sh0000;
            o_bad  <= 8'h00;
        end else begin
            ph_reg <= ph;
            if (ph - ph_reg == 2'h1) o_pos <= o_pos + 16'sh0001;
            else if (ph_reg - ph == 2'h1) o_pos <= o_pos - 16'sh0001;
            else if (ph != ph_reg) o_bad <= o_bad + 8'h01;
        end
    end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the quadrature output block
`timescale 1ns/10ps
module tb_top;
    // ------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [15:0] i_angle = 16'h0000;
    logic        i_index_gate = 1'b0;
    logic [15:0] o_rdata;
    logic        o_out_a_true, o_out_a_comp, o_out_b_true, o_out_b_comp;
    logic        o_out_index_true, o_out_index_comp;
    logic signed [15:0] cnt;
    logic [7:0]  mbad;
    logic [31:0] rnd = 32'hBE237355;
    int          bad_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    wire  [15:0] pins = {10'h000, o_out_a_true, o_out_a_comp, o_out_b_true, o_out_b_comp,
                         o_out_index_true, o_out_index_comp};
    logic [14:0] codes [18] = '{15'h00E0, 15'h01B0, 15'h02A0, 15'h0398, 15'h0414, 15'h0590,
        15'h078C, 15'h090A, 15'h0B88, 15'h0F86, 15'h1305, 15'h1784, 15'h1804, 15'h1F83,
        15'h2F82, 15'h3102, 15'h5F81, 15'h6301};
    int          ipfs [18] = '{1, 2, 3, 4, 5, 6, 8, 10, 12, 16, 20, 24, 25, 32, 48, 50, 96, 100};
    iqo_top #(.SYNC_STAGES(2)) iqo_top_i (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_angle, .i_index_gate, .o_out_a_true, .o_out_a_comp, .o_out_b_true,
        .o_out_b_comp, .o_out_index_true, .o_out_index_comp);
    iqo_counter_model iqo_counter_model_i (.i_clk, .i_rst, .i_a_true(o_out_a_true),
        .i_b_true(o_out_b_true), .o_pos(cnt), .o_bad(mbad));
    always #20 i_clk = ~i_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Pins expected at step s with factor four
    function automatic logic [15:0] pins_exp(input logic [7:0] c, input logic [7:0] p,
                                             input int s, input logic g);
        logic a, b, x, y, z;
        a = s % 4 < 2;
        b = s % 4 == 0 || s % 4 == 3;
        x = (c[4] ? b : a) ^ c[7];
        y = (c[4] ? a : b) ^ c[6];
        z = (g & c[3 - s % 4] & (!p[7] || (p[6:0] < 7'h04 && p[6:0] == s / 4))) ^ c[5];
        return {10'h000, x, !x, y, !y, z, !z};
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        chk(n, e, o_rdata);
        @(posedge i_clk);
    endtask
    // One input period forward at random speed, at most 64 per clock
    task automatic sweep(input logic [14:0] code, input int f);
        int acc;
        logic signed [15:0] p0;
        wr(iqo_pkg::OFS_RES, {1'b0, code});
        rd(iqo_pkg::OFS_STATUS, {f[6:0], 9'h000}, "status");
        p0 = cnt;
        acc = 0;
        while (acc < 65536) begin
            rnd = lfsr(rnd);
            acc = acc + 1 + rnd[5:0];
            i_angle <= acc[15:0];
            @(posedge i_clk);
        end
        tick(4);
        chk("edges", 16'(4 * f), 16'(cnt - p0));
        rd(iqo_pkg::OFS_STATUS, {f[6:0], 9'h000}, "status");
    endtask
    task automatic hys(input logic [14:0] code, input logic [3:0] h, input int pre);
        int s, hv, bb;
        int ang [5];
        logic [1:0] ex [5];
        s = (code == 15'h00E0) ? 16384 : 8192;
        hv = (h == 4'hE) ? s / 2 : (h == 4'hF) ? s : h * 164;
        bb = 2 * s;
        ang = '{pre, bb + hv - 1, bb + hv, bb - hv, bb - hv - 1};
        ex = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h2};
        wr(iqo_pkg::OFS_RES, {1'b0, code});
        wr(iqo_pkg::OFS_HYS, {12'h000, h});
        for (int k = 0; k < 5; k++) begin
            i_angle <= 16'(ang[k]);
            tick(6);
            chk("ab", 16'(ex[k]), 16'({pins[5], pins[3]}));
        end
        wr(iqo_pkg::OFS_HYS, 16'h0000);
        i_angle <= 16'h0000;
        tick(6);
    endtask
    task automatic outs(input logic [7:0] c, input logic [7:0] p, input logic g);
        wr(iqo_pkg::OFS_OUT_CFG, {8'h00, c});
        wr(iqo_pkg::OFS_IDX_POS, {8'h00, p});
        i_index_gate <= g;
        for (int s = 0; s < 16; s++) begin
            i_angle <= 16'(s * 4096 + 2048);
            tick(6);
            chk("pins", pins_exp(c, p, s, g), pins);
        end
        i_angle <= 16'h0000;
        tick(6);
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        tick(6);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rd(iqo_pkg::OFS_OUT_CFG, 16'h0008, "cfg");
        rd(iqo_pkg::OFS_IDX_POS, 16'h0000, "pos");
        rd(iqo_pkg::OFS_RES, 16'h00E0, "res");
        rd(iqo_pkg::OFS_HYS, 16'h0000, "hys");
        rd(iqo_pkg::OFS_SYNC, 16'h0000, "sync");
        wr(8'h55, 16'hFFFF);
        rd(8'h55, 16'h0000, "unmapped");
        wr(iqo_pkg::OFS_HYS, 16'h00F5);
        rd(iqo_pkg::OFS_HYS, 16'h0005, "hys");
        wr(iqo_pkg::OFS_HYS, 16'h0000);
        wr(iqo_pkg::OFS_RES, 16'h1234);
        rd(iqo_pkg::OFS_STATUS, 16'h0200, "status");
        for (int k = 0; k < 18; k++) sweep(codes[k], ipfs[k]);
        // Step 15 of 16, then shrink to 4 steps: walk back to step 3
        wr(iqo_pkg::OFS_RES, 16'h0398);
        i_angle <= 16'hF800;
        tick(20);
        wr(iqo_pkg::OFS_RES, 16'h00E0);
        tick(16);
        rd(iqo_pkg::OFS_STATUS, 16'h0203, "shrink");
        chk("double", 16'h0000, {8'h00, mbad});
        hys(15'h00E0, 4'h0, 32767);
        hys(15'h00E0, 4'h1, 32767);
        hys(15'h00E0, 4'hD, 32767);
        hys(15'h00E0, 4'hE, 32767);
        hys(15'h01B0, 4'hF, 16384);
        wr(iqo_pkg::OFS_RES, 16'h0398);
        outs(8'h08, 8'h00, 1'b1);
        outs(8'hFF, 8'h83, 1'b1);
        outs(8'h1F, 8'h84, 1'b1);
        for (int k = 0; k < 5; k++) begin
            rnd = lfsr(rnd);
            outs(rnd[7:0], {rnd[15], 4'h0, rnd[10:8]}, 1'b1);
        end
        outs(8'hAF, 8'h00, 1'b0);
        wr(iqo_pkg::OFS_OUT_CFG, 16'h000F);
        wr(iqo_pkg::OFS_SYNC, 16'h0010);
        i_angle <= 16'h1800;
        tick(8);
        i_index_gate <= 1'b1;
        tick(8);
        chk("hold", 16'h0000, 16'(o_out_index_true));
        i_angle <= 16'h2800;
        tick(8);
        chk("synced", 16'h0001, 16'(o_out_index_true));
        wrap_up();
    end
endmodule
